// ---- testbench.sv ----
// Purpose: word unit bench
// Assumes: model issues requests
// Notes: fixed operands
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import word_logic_arith_pkg::*;
  logic clk_in = 0, nrst_in = 0, st, dn, cy, bz, tw, de;
  op_t op;
  logic [15:0] a, b, r0, r1;
  int err_count = 0, n_compared = 0, cyc = 0;
  always #10 clk_in = ~clk_in;
  wlau_seq i_wlau_seq (.clk_in, .start_out(st), .op_out(op), .a_out(a), .b_out(b));
  word_logic_arith_unit i_word_logic_arith_unit (.clk_in, .nrst_in, .start_in(st),
    .op_in(op), .opa_in(a), .opb_in(b), .busy_out(bz), .done_out(dn), .res0_out(r0),
    .res1_out(r1), .two_words_out(tw), .div_error_out(de), .carry_flag_out(cy));
  task automatic chk(logic [31:0] g, e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wait_done;
    for (int i = 0; i < 20 && dn !== 1'b1; i++) @(negedge clk_in);
  endtask
  task automatic run(op_t o, logic [15:0] x, y);
    i_wlau_seq.issue(o, x, y);
    wait_done;
  endtask
  task automatic t_logic;
    run(word_or_op, 16'hA5F0, 16'h0FF0);
    chk(r0, 16'hAFF0);
    run(word_differ_op, 16'hA5F0, 16'h0FF0);
    chk(r0, 16'hAA00);
    run(word_equal_op, 16'hA5F0, 16'h0FF0);
    chk(r0, 16'h55FF);
    chk(tw, 1'b0);
    $display("logic done");
  endtask
  task automatic t_carry;
    run(carry_set_op, 16'h0, 16'h0);
    chk(cy, 1'h1);
    run(binary_sum_op, 16'hFFFF, 16'h0001);
    chk({cy, r0}, 17'h10001);
    run(binary_difference_op, 16'h0005, 16'h0003);
    chk({cy, r0}, 17'h00001);
    run(carry_clear_op, 16'h0, 16'h0);
    chk(cy, 1'h0);
    run(binary_difference_op, 16'h0000, 16'h0001);
    chk({cy, r0}, 17'h1FFFF);
    run(bcd_plus_one_op, 16'h0999, 16'h0);
    chk({cy, r0}, 17'h11000);
    run(bcd_minus_one_op, 16'h1000, 16'h0);
    chk({cy, r0}, 17'h10999);
    $display("carry done");
  endtask
  task automatic t_muldiv;
    run(binary_product_op, 16'hFFFF, 16'hFFFF);
    chk({r1, r0}, 32'hFFFE0001);
    chk(tw, 1'b1);
    i_wlau_seq.issue(binary_quotient_op, 16'hFFFF, 16'h0010);
    chk(bz, 1'b1);
    wait_done;
    chk({r1, r0}, 32'h000F0FFF);
    chk(tw, 1'b1);
    run(binary_quotient_op, 16'h1234, 16'h0000);
    chk(de, 1'b1);
    chk({r1, r0}, 32'h000F0FFF);
    run(binary_quotient_op, 16'h0007, 16'h0002);
    chk({de, r1, r0}, 33'h000010003);
    $display("muldiv done");
  endtask
  task automatic t_reset;
    run(carry_set_op, 16'h0, 16'h0);
    nrst_in = 0;
    @(negedge clk_in);
    chk({cy, dn, bz, de, r0}, 20'h00000);
    repeat (2) @(negedge clk_in);
    nrst_in = 1;
    run(word_or_op, 16'h1200, 16'h0034);
    chk(r0, 16'h1234);
    $display("reset done");
  endtask
  task automatic complete_run;
    $display("compared %0d failed %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // a hang ends the run as a failure
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 500) begin
      err_count++;
      complete_run;
    end
  end
  initial begin
    repeat (6) @(negedge clk_in);
    nrst_in = 1;
    t_logic;
    t_carry;
    t_muldiv;
    t_reset;
    complete_run;
  end
endmodule
`default_nettype wire

// ---- wlau_asserts.sv ----
// Purpose: port checker
// Assumes: answers one cycle on
// Notes: divide answers 18 cycles on
`timescale 1ns/1ps
`default_nettype none
module wlau_chk
  import word_logic_arith_pkg::*;
(
  input wire logic clk_in, nrst_in, start_in, busy_out, done_out, carry_flag_out, div_error_out,
  input wire op_t op_in,
  input wire logic [15:0] opa_in, opb_in, res0_out, res1_out
);
  logic [15:0] a_q, b_q;
  logic c_q;
  always_ff @(posedge clk_in) {a_q, b_q, c_q} <= {opa_in, opb_in, carry_flag_out};
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_go(op_t o); start_in && !busy_out && op_in == o; endsequence
  property p_or; s_go(word_or_op) |=> res0_out == (a_q | b_q); endproperty
  a_or: assert property (p_or) else $error("or");
  property p_xor; s_go(word_differ_op) |=> res0_out == (a_q ^ b_q); endproperty
  a_xor: assert property (p_xor) else $error("xor");
  property p_xnor; s_go(word_equal_op) |=> res0_out == ~(a_q ^ b_q); endproperty
  a_xnor: assert property (p_xnor) else $error("xnor");
  property p_dec; s_go(bcd_minus_one_op) |=> carry_flag_out == c_q; endproperty
  a_dec: assert property (p_dec) else $error("dec");
  sequence s_div_go; s_go(binary_quotient_op) ##0 opb_in != 16'h0; endsequence
  property p_dz; s_go(binary_quotient_op) ##0 opb_in == 16'h0 |=> div_error_out && done_out;
  endproperty
  a_dz: assert property (p_dz) else $error("div zero");
  property p_set; s_go(carry_set_op) |=> carry_flag_out; endproperty
  a_set: assert property (p_set) else $error("set");
  property p_clr; s_go(carry_clear_op) |=> !carry_flag_out; endproperty
  a_clr: assert property (p_clr) else $error("clr");
  property p_inc; s_go(bcd_plus_one_op) |=> carry_flag_out == c_q; endproperty
  a_inc: assert property (p_inc) else $error("inc");
  property p_add; s_go(binary_sum_op) |=> {carry_flag_out, res0_out} == a_q + b_q + c_q;
  endproperty
  a_add: assert property (p_add) else $error("add");
  property p_sub; s_go(binary_difference_op) |=>
    {carry_flag_out, res0_out} == a_q - b_q - c_q; endproperty
  a_sub: assert property (p_sub) else $error("sub");
  property p_mul; s_go(binary_product_op) |=> {res1_out, res0_out} == a_q * b_q; endproperty
  a_mul: assert property (p_mul) else $error("mul");
  property p_div; s_div_go |-> ##18 done_out && res0_out == $past(opa_in, 18) / $past(opb_in, 18)
    && res1_out == $past(opa_in, 18) % $past(opb_in, 18); endproperty
  a_div: assert property (p_div) else $error("div");
endmodule
bind word_logic_arith_unit wlau_chk i_wlau_chk (.*);
`default_nettype wire

// ---- wlau_seq.sv ----
// Purpose: sequencer model
// Assumes: issues only while idle
// Notes: operands go inverse once taken
`timescale 1ns/1ps
`default_nettype none
module wlau_seq
  import word_logic_arith_pkg::*;
(
  input wire logic clk_in,
  output logic start_out,
  output var op_t op_out,
  output logic [15:0] a_out, b_out
);
  initial {start_out, op_out, a_out, b_out} = '0;
  task automatic issue(op_t o, logic [15:0] x, y);
    @(negedge clk_in);
    {start_out, op_out, a_out, b_out} = {1'b1, o, x, y};
    @(negedge clk_in);
    {start_out, a_out, b_out} = {1'b0, ~x, ~y};
  endtask
endmodule
`default_nettype wire

// ---- word_logic_arith_pkg.sv ----
// Purpose: types for the word logic and arithmetic unit
// Assumes: defs header included
// Notes: opcode values are local choices
`include "word_logic_arith_unit_defs.svh"
package word_logic_arith_pkg;
  typedef enum logic [`WLAU_OP_W-1:0] {
    word_or_op = 4'h0,
    word_differ_op = 4'h1,
    word_equal_op = 4'h2,
    bcd_plus_one_op = 4'h3,
    bcd_minus_one_op = 4'h4,
    carry_set_op = 4'h5,
    carry_clear_op = 4'h6,
    binary_sum_op = 4'h7,
    binary_difference_op = 4'h8,
    binary_product_op = 4'h9,
    binary_quotient_op = 4'hA
  } op_t;
  typedef enum {st_idle, st_div, st_done} state_t;
  typedef struct packed {
    state_t st;
    logic carry_flag;
    logic [15:0] res0;
    logic [15:0] res1;
    logic [15:0] divisor;
    logic [16:0] rem;
    logic [15:0] quo;
    logic [4:0] cnt;
    logic done;
    logic two;
    logic div_err;
  } regs_t;
endpackage

// ---- word_logic_arith_unit.sv ----
// Purpose: 16-bit logic/arithmetic datapath for a controller cpu
// Assumes: sequencer holds operands while start_in pulses; one clock
// Notes: divide is iterative, 16 steps over 18 cycles; others finish in one
`timescale 1ns/1ps
`default_nettype none
`include "word_logic_arith_unit_defs.svh"
module word_logic_arith_unit (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // request
  input wire logic start_in,
  input wire word_logic_arith_pkg::op_t op_in,
  input wire logic [15:0] opa_in,
  input wire logic [15:0] opb_in,
  // answer
  output logic busy_out,
  output logic done_out,
  output logic [15:0] res0_out,
  output logic [15:0] res1_out,
  output logic two_words_out,
  output logic div_error_out,
  output logic carry_flag_out
);
  import word_logic_arith_pkg::*;

  regs_t q, d;

  // sizes follow the shared constants
  localparam int WORD_W = `WLAU_WORD_W;
  localparam int DIGITS = WORD_W / 4;
  localparam int STEPS = `WLAU_DIV_STEPS;

  // every one-cycle result is formed each cycle; the opcode only picks one
  logic [15:0] or_word;
  logic [15:0] differ_word;
  logic [15:0] equal_word;
  logic [15:0] bcd_up_word;
  logic [15:0] bcd_down_word;
  logic [16:0] sum;
  logic [16:0] dif;
  logic [31:0] prod;

  // shift-add rows of the product
  logic [31:0] pp_row [WORD_W];
  logic [31:0] pp_acc [WORD_W+1];

  // divide step
  logic [16:0] rem_shift;
  logic [16:0] trial;
  logic trial_fits;
  logic last_step;

  // request decode
  logic take;
  logic div_by_zero;

  // bcd digit chains: bit i is high when digit i has to change
  logic [DIGITS-1:0] up_chain;
  logic [DIGITS-1:0] down_chain;

  // opcodes that answer with a second result word
  function automatic logic two_word_op(input op_t o);
    logic r;
    case (o)
      binary_product_op: begin
        r = 1'b1;
      end

      binary_quotient_op: begin
        r = 1'b1;
      end

      default: begin
        r = 1'b0;
      end
    endcase
    return r;
  endfunction

  // carry after an accepted opcode
  function automatic logic carry_after(input op_t o, input logic cur,
                                       input logic add_c, input logic sub_b);
    logic r;
    r = cur;
    case (o)
      carry_set_op: begin
        r = 1'b1;
      end

      carry_clear_op: begin
        r = 1'b0;
      end

      binary_sum_op: begin
        r = add_c;
      end

      binary_difference_op: begin
        r = sub_b;
      end

      default: begin
        r = cur;
      end
    endcase
    return r;
  endfunction

  // digit codes nine and above roll over on increment
  function automatic logic digit_tops(input logic [3:0] v);
    return (v >= 4'h9);
  endfunction

  // a zero digit borrows on decrement
  function automatic logic digit_zero(input logic [3:0] v);
    return (v == 4'h0);
  endfunction

  // a request while dividing is dropped; the sequencer must watch busy
  assign take = start_in & (q.st == st_idle);
  assign div_by_zero = (opb_in == 16'h0000);

  for (genvar b = 0; b < WORD_W; b++) begin : g_bit
    assign or_word[b] = opa_in[b] | opb_in[b];
    assign differ_word[b] = opa_in[b] ^ opb_in[b];
    assign equal_word[b] = ~(opa_in[b] ^ opb_in[b]);
  end

  assign sum = {1'b0, opa_in} + {1'b0, opb_in} + {16'h0000, q.carry_flag};
  assign dif = {1'b0, opa_in} - {1'b0, opb_in} - {16'h0000, q.carry_flag};

  // full 32-bit product
  // a ripple of row adders: small, but the longest path of the block
  assign pp_acc[0] = 32'h00000000;
  for (genvar m = 0; m < WORD_W; m++) begin : g_row
    assign pp_row[m] = opb_in[m] ? ({16'h0000, opa_in} << m) : 32'h00000000;
    assign pp_acc[m+1] = pp_acc[m] + pp_row[m];
  end
  assign prod = pp_acc[WORD_W];

  // divisor is held in a register so the operands may change once taken
  assign rem_shift = {q.rem[15:0], q.quo[15]};
  assign trial = rem_shift - {1'b0, q.divisor};
  assign trial_fits = ~trial[16];
  assign last_step = (q.cnt == 5'(STEPS - 1));

  assign up_chain[0] = 1'b1;
  assign down_chain[0] = 1'b1;
  for (genvar g = 0; g < DIGITS; g++) begin : g_digit
    logic [3:0] digit;
    logic [3:0] digit_up;
    logic [3:0] digit_down;
    assign digit = opa_in[g*4 +: 4];
    // digit increment
    // codes above nine count as nine so a bad digit still rolls over
    assign digit_up = digit_tops(digit) ? 4'h0 : digit + 4'h1;
    assign bcd_up_word[g*4 +: 4] = up_chain[g] ? digit_up : digit;
    assign digit_down = digit_zero(digit) ? 4'h9 : digit - 4'h1;
    assign bcd_down_word[g*4 +: 4] = down_chain[g] ? digit_down : digit;
    if (g < DIGITS - 1) begin : g_ripple
      assign up_chain[g+1] = up_chain[g] & digit_tops(digit);
      assign down_chain[g+1] = down_chain[g] & digit_zero(digit);
    end
  end

  // done is a one-cycle pulse; results stand until the next opcode
  always_comb begin
    d = q;
    d.done = 1'b0;
    case (q.st)
      st_idle: begin
        if (take) begin
          d.done = 1'b1;
          d.two = two_word_op(op_in);
          d.carry_flag = carry_after(op_in, q.carry_flag, sum[16], dif[16]);
          if (!two_word_op(op_in)) begin
            d.res1 = 16'h0000;
          end
          case (op_in)
            word_or_op: begin
              d.res0 = or_word;
            end

            word_differ_op: begin
              d.res0 = differ_word;
            end

            word_equal_op: begin
              d.res0 = equal_word;
            end

            bcd_plus_one_op: begin
              d.res0 = bcd_up_word;
            end

            bcd_minus_one_op: begin
              d.res0 = bcd_down_word;
            end

            binary_sum_op: begin
              d.res0 = sum[15:0];
            end

            binary_difference_op: begin
              d.res0 = dif[15:0];
            end

            binary_product_op: begin
              d.res0 = prod[15:0];
              d.res1 = prod[31:16];
            end

            binary_quotient_op: begin
              // a zero divisor flags an error and leaves both words alone
              if (div_by_zero) begin
                d.div_err = 1'b1;
              end else begin
                d.div_err = 1'b0;
                d.done = 1'b0;
                d.st = st_div;
                d.divisor = opb_in;
                d.quo = opa_in;
                d.rem = 17'h00000;
                d.cnt = 5'h00;
              end
            end

            default: begin
              // carry-only and unknown opcodes keep res0; res1 was cleared above
              d.done = 1'b1;
            end
          endcase
        end
      end

      st_div: begin
        // restoring division, one quotient bit per cycle
        if (trial_fits) begin
          d.rem = trial;
          d.quo = {q.quo[14:0], 1'b1};
        end else begin
          d.rem = rem_shift;
          d.quo = {q.quo[14:0], 1'b0};
        end
        d.cnt = q.cnt + 5'h01;
        if (last_step) begin
          d.st = st_done;
        end
      end

      st_done: begin
        d.res0 = q.quo;
        d.res1 = q.rem[15:0];
        d.done = 1'b1;
        d.st = st_idle;
      end

      default: begin
        d.st = st_idle;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q <= '{st: st_idle, carry_flag: `WLAU_CARRY_RST, default: '0};
    end else begin
      q <= d;
    end
  end

  assign busy_out = (q.st != st_idle);
  assign done_out = q.done;
  assign res0_out = q.res0;
  assign res1_out = q.res1;
  assign two_words_out = q.two;
  assign div_error_out = q.div_err;
  assign carry_flag_out = q.carry_flag;
endmodule
`default_nettype wire

// ---- word_logic_arith_unit_defs.svh ----
// Purpose: constants for the word logic and arithmetic unit
// Assumes: 16-bit words, 50 MHz clock
// Notes: opcode encodings are local choices
`ifndef WORD_LOGIC_ARITH_UNIT_DEFS_SVH
`define WORD_LOGIC_ARITH_UNIT_DEFS_SVH
`define WLAU_WORD_W 16
`define WLAU_OP_W 4
`define WLAU_CARRY_RST 1'b0
`define WLAU_DIV_STEPS 16
`endif
